/* rtl/crs_core_regs.sv */
`timescale 1ns/100ps
// Notes on behaviour
// [RULE1] 16-bit PC, flat 16K program space
// [RULE2] Accumulator takes every source-mode result
// [RULE3] Index register supplies indexed address offset
// [RULE4] Stack instructions move the stack pointer
// [RULE5] Swap and add may also write SP
// [RULE6] Zero bit1, carry bit2, supervisor bit3
// [RULE7] Flag bit0 gates all interrupts globally
// [RULE8] Flag bit4 selects register bank
// [RULE9] Supervisor bit read-only to user code
// [RULE10] Carry flag reflects last operation carry
// [RULE11] Zero flag reflects last zero result
// [RULE12] Operations update flags per own enables
// [RULE13] Flags as destination written only by logical instructions
// [RULE14] Core registers not in peripheral space
// [RULE15] Stack pointer 8 bits, resets zero
// [RULE16] Index register 8 bits, resets zero
// [RULE17] Reserved flag bits read zero always
module crs_core_regs
    import crs_pkg::*;
#(
    parameter int PROG_AW = PROG_AW_DEF
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Execution results
    input wire crs_alu_type alu_i,
    input wire crs_stack_type stack_op_i,
    input wire crs_pc_cmd_type pc_cmd_i,
    // Supervisor entry and exit
    input wire logic sup_enter_i,
    input wire logic sup_exit_i,
    // Interrupt gating
    input wire logic irq_req_i,
    output logic irq_take_o,
    // Register contents
    output logic [PC_W-1:0] pc_o,
    output logic [PROG_AW-1:0] prog_addr_o,
    output logic [DATA_W-1:0] acc_o,
    output logic [DATA_W-1:0] index_o,
    output logic [DATA_W-1:0] sp_o,
    output logic [DATA_W-1:0] flags_o,
    output logic reg_bank_select_o
);

    // ==========================================================
    // Elaboration check
    if (PROG_AW < 1 || PROG_AW > PC_W) begin
        $error("PROG_AW must lie between 1 and PC_W");
    end

    // ==========================================================
    // State
    logic [PC_W-1:0] pc_ff, nxt_pc;
    logic [7:0] acc_ff, nxt_acc;
    logic [7:0] idx_ff, nxt_idx;
    logic [7:0] sp_ff, nxt_sp;
    logic [7:0] flags_ff, nxt_flags;
    logic [7:0] flog_res;
    logic alu_sp;

    // ==========================================================
    // Program counter
    always_comb begin
        nxt_pc = pc_ff;
        // [RULE1] flat 16-bit count
        if (pc_cmd_i.load) begin
            nxt_pc = pc_cmd_i.target;
        end else if (pc_cmd_i.inc) begin
            nxt_pc = pc_ff + {14'h0000, pc_cmd_i.step};
        end
    end

    // ==========================================================
    // Accumulator and index
    always_comb begin
        nxt_acc = acc_ff;
        nxt_idx = idx_ff;
        // [RULE2] result into accumulator
        if (alu_i.valid && alu_i.dest == DST_A) begin
            nxt_acc = alu_i.value;
        end
        // [RULE16] index load
        if (alu_i.valid && alu_i.dest == DST_X) begin
            nxt_idx = alu_i.value;
        end
    end

    // ==========================================================
    // Stack pointer; a swap or add on SP wins over a stack move
    assign alu_sp = alu_i.valid && alu_i.dest == DST_SP;

    always_comb begin
        nxt_sp = sp_ff;
        // [RULE5] swap or add result
        if (alu_sp) begin
            nxt_sp = alu_i.value;
        end else begin
            // [RULE4] stack instruction moves
            unique case (stack_op_i)
                STK_PUSH: nxt_sp = sp_ff + SP_STEP_1;
                STK_POP: nxt_sp = sp_ff - SP_STEP_1;
                STK_CALL: nxt_sp = sp_ff + SP_STEP_2;
                STK_LONG_CALL_INSTR: nxt_sp = sp_ff + SP_STEP_2;
                STK_RET: nxt_sp = sp_ff - SP_STEP_2;
                STK_RETURN_FROM_IRQ_INSTR: nxt_sp = sp_ff - SP_STEP_3;
                default: nxt_sp = sp_ff;
            endcase
        end
    end

    // ==========================================================
    // Flags
    always_comb begin
        unique case (alu_i.flog)
            FLOG_AND: flog_res = flags_ff & alu_i.value;
            FLOG_OR: flog_res = flags_ff | alu_i.value;
            FLOG_XOR: flog_res = flags_ff ^ alu_i.value;
            default: flog_res = flags_ff;
        endcase
    end

    always_comb begin
        nxt_flags = flags_ff;
        if (alu_i.valid && alu_i.dest == DST_F) begin
            // [RULE13] logical write, masked bits
            nxt_flags = (flog_res & FLAGS_WMASK) | (flags_ff & ~FLAGS_WMASK);
        end else if (alu_i.valid) begin
            // [RULE12] per-operation flag enables
            if (alu_i.upd_zero) begin
                // [RULE11] zero result
                nxt_flags[FLAG_ZERO] = (alu_i.value == ZERO_BYTE);
            end
            if (alu_i.upd_carry) begin
                // [RULE10] carry out
                nxt_flags[FLAG_CARRY] = alu_i.carry;
            end
        end
        // [RULE9] only hardware entry and exit
        if (sup_enter_i) begin
            nxt_flags[FLAG_SUPER] = 1'b1;
        end else if (sup_exit_i) begin
            nxt_flags[FLAG_SUPER] = 1'b0;
        end
        // [RULE17] reserved bits held low
        nxt_flags[7:5] = 3'b000;
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk_i) begin
        // [RULE15] power-on values
        if (sys_rst_i) begin
            pc_ff <= PC_RST;
            acc_ff <= REG_RST;
            idx_ff <= REG_RST;
            sp_ff <= REG_RST;
            flags_ff <= FLAGS_RST;
        end else begin
            pc_ff <= nxt_pc;
            acc_ff <= nxt_acc;
            idx_ff <= nxt_idx;
            sp_ff <= nxt_sp;
            flags_ff <= nxt_flags;
        end
    end

    // ==========================================================
    // Outputs; no register-space port exists for these
    // [RULE14] read-only views only
    assign pc_o = pc_ff;
    assign prog_addr_o = pc_ff[PROG_AW-1:0];
    assign acc_o = acc_ff;
    // [RULE3] offset for indexed modes
    assign index_o = idx_ff;
    assign sp_o = sp_ff;
    // [RULE6] flag layout
    assign flags_o = flags_ff;
    // [RULE8] bank select
    assign reg_bank_select_o = flags_ff[FLAG_BANK];
    // [RULE7] global enable gate
    assign irq_take_o = irq_req_i & flags_ff[FLAG_GIE];

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_push_only;
        stack_op_i == STK_PUSH && !alu_sp;
    endsequence

    sequence s_return_from_irq_instr_only;
        stack_op_i == STK_RETURN_FROM_IRQ_INSTR && !alu_sp;
    endsequence

    sequence s_pop_only;
        stack_op_i == STK_POP && !alu_sp;
    endsequence

    sequence s_call_only;
        (stack_op_i == STK_CALL || stack_op_i == STK_LONG_CALL_INSTR) && !alu_sp;
    endsequence

    sequence s_ret_only;
        stack_op_i == STK_RET && !alu_sp;
    endsequence

    a_pc_load_target: assert property ( // [RULE1]
        pc_cmd_i.load |=> pc_o == $past(pc_cmd_i.target))
        else $error("PC did not take load target");

    a_pc_step_add: assert property ( // [RULE1]
        !pc_cmd_i.load && pc_cmd_i.inc |=>
        pc_o == $past(pc_o) + {14'h0000, $past(pc_cmd_i.step)})
        else $error("PC did not advance by step");

    a_pc_hold_idle: assert property ( // [RULE1]
        !pc_cmd_i.load && !pc_cmd_i.inc |=> $stable(pc_o))
        else $error("PC moved without a command");

    a_acc_takes_result: assert property ( // [RULE2]
        alu_i.valid && alu_i.dest == DST_A |=> acc_o == $past(alu_i.value))
        else $error("Accumulator missed result");

    a_acc_hold_idle: assert property ( // [RULE2]
        !(alu_i.valid && alu_i.dest == DST_A) |=> $stable(acc_o))
        else $error("Accumulator changed without a result");

    a_sp_push_step: assert property ( // [RULE4]
        s_push_only |=> sp_o == $past(sp_o) + SP_STEP_1)
        else $error("Push did not raise SP by one");

    a_sp_return_from_irq_instr_step: assert property ( // [RULE4]
        s_return_from_irq_instr_only |=> sp_o == $past(sp_o) - SP_STEP_3)
        else $error("Return from interrupt did not drop SP by three");

    a_sp_pop_step: assert property ( // [RULE4]
        s_pop_only |=> sp_o == $past(sp_o) - SP_STEP_1)
        else $error("Pop did not drop SP by one");

    a_sp_call_step: assert property ( // [RULE4]
        s_call_only |=> sp_o == $past(sp_o) + SP_STEP_2)
        else $error("Call did not raise SP by two");

    a_sp_ret_step: assert property ( // [RULE4]
        s_ret_only |=> sp_o == $past(sp_o) - SP_STEP_2)
        else $error("Return did not drop SP by two");

    a_sp_hold_idle: assert property ( // [RULE4]
        stack_op_i == STK_NONE && !alu_sp |=> $stable(sp_o))
        else $error("SP changed without a stack instruction");

    a_sp_alu_write: assert property ( // [RULE5]
        alu_sp |=> sp_o == $past(alu_i.value))
        else $error("SP missed swap or add result");

    a_index_hold: assert property ( // [RULE16]
        !(alu_i.valid && alu_i.dest == DST_X) |=> $stable(index_o))
        else $error("Index changed without a write");

    a_index_load: assert property ( // [RULE16]
        alu_i.valid && alu_i.dest == DST_X |=> index_o == $past(alu_i.value))
        else $error("Index missed its load");

    a_zero_flag_set: assert property ( // [RULE11]
        alu_i.valid && alu_i.dest != DST_F && alu_i.upd_zero |=>
        flags_o[FLAG_ZERO] == ($past(alu_i.value) == ZERO_BYTE))
        else $error("Zero flag wrong after operation");

    a_carry_flag_set: assert property ( // [RULE10]
        alu_i.valid && alu_i.dest != DST_F && alu_i.upd_carry |=>
        flags_o[FLAG_CARRY] == $past(alu_i.carry))
        else $error("Carry flag wrong after operation");

    a_super_kept: assert property ( // [RULE9]
        !sup_enter_i && !sup_exit_i |=> $stable(flags_o[FLAG_SUPER]))
        else $error("Supervisor bit changed without entry or exit");

    a_super_enter: assert property ( // [RULE9]
        sup_enter_i |=> flags_o[FLAG_SUPER])
        else $error("Supervisor bit not set on entry");

    a_super_exit: assert property ( // [RULE9]
        !sup_enter_i && sup_exit_i |=> !flags_o[FLAG_SUPER])
        else $error("Supervisor bit not cleared on exit");

    a_flags_hold_idle: assert property ( // [RULE13]
        !alu_i.valid && !sup_enter_i && !sup_exit_i |=> $stable(flags_o))
        else $error("Flags changed without an operation");

    a_reserved_zero: assert property ( // [RULE17]
        flags_o[7:5] == 3'b000)
        else $error("Reserved flag bits not zero");

    a_irq_gated: assert property ( // [RULE7]
        irq_req_i && !flags_o[FLAG_GIE] |-> !irq_take_o)
        else $error("Interrupt passed while disabled");

    a_irq_passes: assert property ( // [RULE7]
        irq_req_i && flags_o[FLAG_GIE] |-> irq_take_o)
        else $error("Interrupt blocked while enabled");

    a_bank_follows: assert property ( // [RULE8]
        alu_i.valid && alu_i.dest == DST_F |=>
        reg_bank_select_o == ($past(alu_i.flog) == FLOG_AND ?
            $past(flags_o[FLAG_BANK] & alu_i.value[FLAG_BANK]) :
            $past(alu_i.flog) == FLOG_OR ?
            $past(flags_o[FLAG_BANK] | alu_i.value[FLAG_BANK]) :
            $past(flags_o[FLAG_BANK] ^ alu_i.value[FLAG_BANK])))
        else $error("Bank select missed flag write");

endmodule

/* rtl/crs_pkg.sv */
// ==========================================================
// Core register set constants and types
package crs_pkg;
    // Widths
    localparam int PC_W = 16;
    localparam int DATA_W = 8;
    localparam int PROG_AW_DEF = 14;
    // Flag bit positions
    localparam int FLAG_GIE = 0;
    localparam int FLAG_ZERO = 1;
    localparam int FLAG_CARRY = 2;
    localparam int FLAG_SUPER = 3;
    localparam int FLAG_BANK = 4;
    // Reset values and masks
    localparam logic [7:0] FLAGS_RST = 8'h02;
    localparam logic [7:0] FLAGS_WMASK = 8'h17;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [15:0] PC_RST = 16'h0000;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    // Stack pointer movement per stack instruction
    localparam logic [7:0] SP_STEP_1 = 8'h01;
    localparam logic [7:0] SP_STEP_2 = 8'h02;
    localparam logic [7:0] SP_STEP_3 = 8'h03;

    // Destination of an executed operation
    typedef enum logic [2:0] {
        DST_NONE, DST_A, DST_X, DST_SP, DST_F
    } crs_dest_type;
    // Logical operations that may target the flags
    typedef enum logic [1:0] {
        FLOG_AND, FLOG_OR, FLOG_XOR
    } crs_flog_type;
    // Stack instructions
    typedef enum logic [2:0] {
        STK_NONE, STK_PUSH, STK_POP, STK_CALL, STK_LONG_CALL_INSTR, STK_RET, STK_RETURN_FROM_IRQ_INSTR
    } crs_stack_type;

    // Result of one executed operation
    typedef struct packed {
        logic valid;
        crs_dest_type dest;
        crs_flog_type flog;
        logic [7:0] value;
        logic carry;
        logic upd_zero;
        logic upd_carry;
    } crs_alu_type;
    // Program counter command
    typedef struct packed {
        logic load;
        logic [15:0] target;
        logic inc;
        logic [1:0] step;
    } crs_pc_cmd_type;
endpackage

/* test/crs_testbench.sv */
`timescale 1ns/100ps
module testbench
    import crs_pkg::*;
;
    // ==========================================
    // Signals, expected notes and counters
    typedef struct {
        logic [15:0] pc;
        logic [7:0] acc, idx, sp, flg;
        int due;
    } crs_note_type;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    crs_alu_type alu_i = '0;
    crs_stack_type stack_op_i = STK_NONE;
    crs_pc_cmd_type pc_cmd_i = '0;
    logic sup_enter_i = 1'b0;
    logic sup_exit_i = 1'b0;
    logic irq_req_i = 1'b0;
    logic irq_take_o, reg_bank_select_o;
    logic [15:0] pc_o;
    logic [13:0] prog_addr_o;
    logic [7:0] acc_o, index_o, sp_o, flags_o;
    crs_note_type m, n;
    crs_note_type q_exp[$];
    int failures = 0;
    int tests_run = 0;
    int cyc = 0;
    logic [15:0] r1 = 16'h9bca;
    logic [15:0] r2;
    crs_alu_type a;
    crs_pc_cmd_type p;

    crs_core_regs #(.PROG_AW(14)) i_crs_core_regs (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .alu_i(alu_i), .stack_op_i(stack_op_i),
        .pc_cmd_i(pc_cmd_i), .sup_enter_i(sup_enter_i), .sup_exit_i(sup_exit_i),
        .irq_req_i(irq_req_i), .irq_take_o(irq_take_o), .pc_o(pc_o),
        .prog_addr_o(prog_addr_o), .acc_o(acc_o), .index_o(index_o), .sp_o(sp_o),
        .flags_o(flags_o), .reg_bank_select_o(reg_bank_select_o)
    );

    // ==========================================
    // Clock, cycle count and hang guard
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            failures++;
            complete_run();
        end
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    // Drive one cycle of inputs and note the register state it must give
    task automatic step(input logic r, input crs_alu_type a, input crs_stack_type s,
        input crs_pc_cmd_type p, input logic en, input logic ex, input logic q);
        logic [7:0] f, v;
        @(posedge clk_i);
        sys_rst_i <= r;
        alu_i <= a;
        stack_op_i <= s;
        pc_cmd_i <= p;
        sup_enter_i <= en;
        sup_exit_i <= ex;
        irq_req_i <= q;
        f = m.flg;
        if (r) begin
            m.pc = PC_RST;
            m.acc = REG_RST;
            m.idx = REG_RST;
            m.sp = REG_RST;
            f = FLAGS_RST;
        end else begin
            if (p.load) m.pc = p.target;
            else if (p.inc) m.pc = m.pc + {14'h0000, p.step};
            if (!(a.valid && a.dest == DST_SP)) begin
                case (s)
                    STK_PUSH: m.sp = m.sp + SP_STEP_1;
                    STK_POP: m.sp = m.sp - SP_STEP_1;
                    STK_CALL, STK_LONG_CALL_INSTR: m.sp = m.sp + SP_STEP_2;
                    STK_RET: m.sp = m.sp - SP_STEP_2;
                    STK_RETURN_FROM_IRQ_INSTR: m.sp = m.sp - SP_STEP_3;
                    default: ;
                endcase
            end
            if (a.valid) begin
                case (a.dest)
                    DST_A: m.acc = a.value;
                    DST_X: m.idx = a.value;
                    DST_SP: m.sp = a.value;
                    default: ;
                endcase
                if (a.dest == DST_F) begin
                    case (a.flog)
                        FLOG_AND: v = f & a.value;
                        FLOG_OR: v = f | a.value;
                        default: v = f ^ a.value;
                    endcase
                    f = (f & ~FLAGS_WMASK) | (v & FLAGS_WMASK);
                end else begin
                    if (a.upd_zero) f[FLAG_ZERO] = (a.value == ZERO_BYTE);
                    if (a.upd_carry) f[FLAG_CARRY] = a.carry;
                end
            end
            // Supervisor bit by entry and exit only
            if (en) f[FLAG_SUPER] = 1'b1;
            else if (ex) f[FLAG_SUPER] = 1'b0;
        end
        m.flg = f;
        m.due = cyc + 2;
        q_exp.push_back(m);
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    // ==========================================
    // Watcher compares oldest due note
    always @(negedge clk_i) begin
        if (q_exp.size() > 0 && q_exp[0].due <= cyc) begin
            n = q_exp.pop_front();
            chk("pc", n.pc, pc_o);
            chk("prog_addr", {2'b00, n.pc[13:0]}, {2'b00, prog_addr_o});
            chk("acc", {8'h00, n.acc}, {8'h00, acc_o});
            chk("index", {8'h00, n.idx}, {8'h00, index_o});
            chk("sp", {8'h00, n.sp}, {8'h00, sp_o});
            chk("flags", {8'h00, n.flg}, {8'h00, flags_o});
            chk("bank", {15'h0000, n.flg[FLAG_BANK]}, {15'h0000, reg_bank_select_o});
            chk("irq", {15'h0000, irq_req_i & n.flg[FLAG_GIE]}, {15'h0000, irq_take_o});
        end
    end

    task complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        repeat (4) step(1'b1, '0, STK_NONE, '0, 1'b0, 1'b0, 1'b0);
        step(1'b0, '0, STK_POP, '0, 1'b0, 1'b0, 1'b1);
        step(1'b0, '0, STK_RETURN_FROM_IRQ_INSTR, '{1'b1, 16'hffff, 1'b0, 2'b00}, 1'b1, 1'b1, 1'b1);
        step(1'b0, '0, STK_NONE, '{1'b0, 16'h0000, 1'b1, 2'b11}, 1'b0, 1'b0, 1'b1);
        for (int k = 0; k < 3; k++) begin
            a = '{1'b1, DST_F, crs_flog_type'(k), 8'hff >> (k * 3), 1'b1, 1'b1, 1'b1};
            step(1'b0, a, STK_PUSH, '0, 1'b0, 1'b0, 1'b1);
        end
        for (int i = 0; i < 1600; i++) begin
            r1 = lfsr_next(r1);
            r2 = lfsr_next(lfsr_next(r1));
            r1 = lfsr_next(r2);
            a = '{r1[0], crs_dest_type'(3'(r1[3:1] % 3'd5)),
                  crs_flog_type'(r1[5:4] == 2'b11 ? 2'b01 : r1[5:4]),
                  (r1[15:14] == 2'b00) ? 8'h00 : r1[13:6], r2[0], r2[1], r2[2]};
            p = '{r2[6] & r2[7], {r2[15:8], r1[7:0]}, r2[8], r2[10:9]};
            step(i == 800, a, crs_stack_type'(3'(r2[5:3] % 3'd7)), p,
                r2[11] & r2[12], r2[13], r2[14]);
        end
        repeat (4) @(posedge clk_i);
        complete_run();
    end
endmodule
